// ===== include/exc_status_pkg.sv
// Constants for the drive exception status bytes and the status response block.
// Assumes a single 50 MHz drive clock and byte-wide status storage.
package exc_status_pkg;

  // ==========================================================================
  // Block shape
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned BLOCK_BYTES   = 8;
  localparam int unsigned IDX_W         = 3;
  localparam logic [7:0]  RD_STATUS_CODE = 8'h44;

  // ==========================================================================
  // Byte 0 summary bits
  localparam int unsigned B0_BC_EXC     = 5;
  localparam int unsigned B0_UNSOL      = 6;
  localparam int unsigned B0_RESP_TYPE  = 7;

  // ==========================================================================
  // Byte 2: bus control exceptions
  localparam int unsigned B2_LATE       = 3;
  localparam int unsigned B2_CONTEXT    = 4;
  localparam int unsigned B2_UNSUPP     = 5;
  localparam int unsigned B2_BAD_PARAM  = 6;
  localparam int unsigned B2_BAD_CODE   = 7;

  // ==========================================================================
  // Byte 3: drive hardware faults
  localparam int unsigned B3_TEMP       = 1;
  localparam int unsigned B3_VOLT       = 2;
  localparam int unsigned B3_HEAD_SEL   = 5;
  localparam int unsigned B3_OFF_CYL    = 6;
  localparam int unsigned B3_SPEED      = 7;

  // ==========================================================================
  // Byte 4: write command faults
  localparam int unsigned B4_STROBE     = 3;
  localparam int unsigned B4_OFFSET     = 4;
  localparam int unsigned B4_NO_DATA    = 5;
  localparam int unsigned B4_WPROT      = 7;

  // ==========================================================================
  // Byte 5: internal diagnostics
  localparam int unsigned B5_DIAG_OFF   = 5;
  localparam int unsigned B5_DIAG_INC   = 6;
  localparam int unsigned B5_DIAG_ERR   = 7;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned WR_DATA_WAIT_US = 200;
  localparam int unsigned WR_DATA_WAIT_CYC = WR_DATA_WAIT_US * CLK_MHZ;
  localparam int unsigned HEAD_ADDR_W   = 5;
  localparam int unsigned NUM_HEADS     = 9;

endpackage

// ===== include/flag_bank_if.sv
// Carrier between the status assembler and its sticky flag banks.
// Assumes one byte of flags per instance, all on the drive clock.
`timescale 1ns/100ps
interface flag_bank_if;
  logic [7:0] set;
  logic [7:0] clr;
  logic [7:0] q;
  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ===== verilog/sticky_flag_bank.sv
// One byte of sticky status flags with per-bit set and clear.
// Assumes set and clear are single-clock pulses or levels from the same domain.
`timescale 1ns/100ps
module sticky_flag_bank (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Flag carrier
  flag_bank_if.bank       fb
);

  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;

  // A set in the same cycle as a clear wins, so no event is lost.
  assign nxt_flags = (flags_ff & ~fb.clr) | fb.set;
  assign fb.q      = flags_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_ff <= exc_status_pkg::FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule

// ===== verilog/drive_exception_status_bytes.sv
// Drive exception status bytes 2 to 5 and the 8-byte status response stream.
// Assumes command decode, servo and diagnostic logic share sys_clk; the
// temperature and voltage monitors are asynchronous pins.
//
// Contract
// [R1] Late bus control command sets byte2 bit3
// [R2] Conflicting bus control command sets byte2 bit4
// [R3] Unimplemented bus control command sets byte2 bit5
// [R4] Invalid command parameter sets byte2 bit6
// [R5] Invalid command code sets byte2 bit7
// [R6] Overtemperature sets byte3 bit1
// [R7] Supply out of range sets byte3 bit2
// [R8] Invalid head selection sets byte3 bit5
// [R9] Seek miss or off-cylinder sets byte3 bit6
// [R10] Spin-up or speed loss sets byte3 bit7
// [R11] Write under strobe shift sets byte4 bit3
// [R12] Write with heads offset sets byte4 bit4
// [R13] Accepted write without data sets byte4 bit5
// [R14] Write while protected sets byte4 bit7
// [R15] Diagnostics disabled sets byte5 bit5
// [R16] Diagnostic not executed sets byte5 bit6
// [R17] Diagnostic error sets byte5 bit7
// [R18] Unused bits of bytes 2-5 read zero
// [R19] Read-status code returns the 8-byte block
// [R20] Any command rejection sets byte0 bit5
// [R21] Byte0 bit7 always zero
`timescale 1ns/100ps
module drive_exception_status_bytes #(
  parameter int unsigned WR_DATA_WAIT_CYC = exc_status_pkg::WR_DATA_WAIT_CYC,
  parameter int unsigned NUM_HEADS        = exc_status_pkg::NUM_HEADS
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Bus control commands from the drive bus decoder
  input  wire logic       cmd_strobe,
  input  wire logic [7:0] cmd_code,
  input  wire logic       rej_late,
  input  wire logic       rej_conflict,
  input  wire logic       rej_unsupported,
  input  wire logic       rej_bad_param,
  input  wire logic       rej_bad_code,
  // Hardware monitors, asynchronous pins
  input  wire logic       overtemp_pin,
  input  wire logic       volt_fault_pin,
  // Servo and spindle events
  input  wire logic       head_sel_strobe,
  input  wire logic [4:0] head_sel_addr,
  input  wire logic       off_cyl_event,
  input  wire logic       speed_event,
  input  wire logic       fault_clr,
  // Write path
  input  wire logic       wr_cmd,
  input  wire logic       strobe_shift_on,
  input  wire logic       head_offset_on,
  input  wire logic       write_protect_on,
  input  wire logic       wr_data_start,
  // Diagnostics
  input  wire logic       diag_disable,
  input  wire logic       diag_start,
  input  wire logic       diag_incomplete,
  input  wire logic       diag_error,
  // Other bytes of the block, kept elsewhere
  input  wire logic [7:0] summary_byte_in,
  input  wire logic [7:0] unsol_byte_in,
  input  wire logic [7:0] head_err_byte_in,
  input  wire logic [7:0] data_exc_byte_in,
  // Status response stream
  output logic            stat_valid_ff,
  output logic [7:0]      stat_byte_ff,
  output logic [2:0]      stat_index_ff,
  output logic            stat_last_ff,
  output logic            stat_busy_ff,
  output logic            bc_exception_ff
);

  // ==========================================================================
  // Flag banks, one per exception byte
  // Each exception byte is a bank of sticky flags. A set in the same cycle as
  // its clear wins, so an event is never lost to a clear.
  flag_bank_if bc_fb ();
  flag_bank_if hw_fb ();
  flag_bank_if wr_fb ();
  flag_bank_if dg_fb ();

  sticky_flag_bank u_bc_bank (.sys_clk(sys_clk), .rst(rst), .fb(bc_fb));
  sticky_flag_bank u_hw_bank (.sys_clk(sys_clk), .rst(rst), .fb(hw_fb));
  sticky_flag_bank u_wr_bank (.sys_clk(sys_clk), .rst(rst), .fb(wr_fb));
  sticky_flag_bank u_dg_bank (.sys_clk(sys_clk), .rst(rst), .fb(dg_fb));

  // ==========================================================================
  // Monitor pin synchronisers
  logic [1:0] mon_meta_ff;
  logic [1:0] mon_sync_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mon_meta_ff <= 2'h0;
      mon_sync_ff <= 2'h0;
    end else begin
      mon_meta_ff <= {volt_fault_pin, overtemp_pin};
      mon_sync_ff <= mon_meta_ff;
    end
  end

  // Only the second stage is read, since the first may still be settling.
  wire overtemp_sync = mon_sync_ff[0];
  wire volt_sync     = mon_sync_ff[1];

  // ==========================================================================
  // Command decode
  wire is_rd_status  = cmd_strobe && (cmd_code == exc_status_pkg::RD_STATUS_CODE);
  // A new command other than read-status replaces the cause of the last one,
  // so reading status never wipes the cause it is meant to report.
  wire bc_new_cmd    = cmd_strobe && !is_rd_status;

  // ==========================================================================
  // Byte 2: bus control exceptions
  // Rejection causes come from the bus decoder with the command they describe.
  logic [7:0] bc_set;
  always_comb begin
    bc_set = 8'h00; // [R18]
    bc_set[exc_status_pkg::B2_LATE]      = rej_late;        // [R1]
    bc_set[exc_status_pkg::B2_CONTEXT]   = rej_conflict;    // [R2]
    bc_set[exc_status_pkg::B2_UNSUPP]    = rej_unsupported; // [R3]
    bc_set[exc_status_pkg::B2_BAD_PARAM] = rej_bad_param;   // [R4]
    bc_set[exc_status_pkg::B2_BAD_CODE]  = rej_bad_code;    // [R5]
  end
  assign bc_fb.set = bc_set;
  assign bc_fb.clr = {8{bc_new_cmd}};

  // ==========================================================================
  // Byte 3: drive hardware faults
  // Heads are numbered from zero, so an address at or above the head count
  // is a selection that this drive cannot honour.
  wire head_sel_bad = head_sel_strobe &&
                      ({27'h0, head_sel_addr} >= 32'(NUM_HEADS));
  logic [7:0] hw_set;
  always_comb begin
    hw_set = 8'h00; // [R18]
    hw_set[exc_status_pkg::B3_TEMP]     = overtemp_sync;  // [R6]
    hw_set[exc_status_pkg::B3_VOLT]     = volt_sync;      // [R7]
    hw_set[exc_status_pkg::B3_HEAD_SEL] = head_sel_bad;   // [R8]
    hw_set[exc_status_pkg::B3_OFF_CYL]  = off_cyl_event;  // [R9]
    hw_set[exc_status_pkg::B3_SPEED]    = speed_event;    // [R10]
  end
  assign hw_fb.set = hw_set;
  // A monitor pin that is still high sets its bit again at once, so a clear
  // only sticks once the condition has gone away.
  assign hw_fb.clr = {8{fault_clr}};

  // ==========================================================================
  // Byte 4: write command faults and write data watchdog
  wire wr_refused  = strobe_shift_on || head_offset_on || write_protect_on;
  wire wr_accepted = wr_cmd && !wr_refused;

  // Each refusal reason is reported against the command that met it.
  wire wr_strobe_fault = wr_cmd && strobe_shift_on;  // [R11]
  wire wr_offset_fault = wr_cmd && head_offset_on;   // [R12]
  wire wr_prot_fault   = wr_cmd && write_protect_on; // [R14]

  // The wait counter is 16 bits wide, which is plenty for the default wait;
  // a longer wait would be cut short, the price of a small counter.
  logic [15:0] wr_wait_ff;
  logic        wr_pend_ff;
  logic        wr_timeout;
  logic [15:0] nxt_wr_wait;
  logic        nxt_wr_pend;

  // Data that starts in the very cycle the wait runs out still counts as
  // arrived, so a late but honest transfer is not flagged.
  assign wr_timeout = wr_pend_ff && (wr_wait_ff == 16'h0001) && !wr_data_start;

  always_comb begin
    nxt_wr_wait = wr_wait_ff;
    nxt_wr_pend = wr_pend_ff;
    if (wr_accepted) begin
      nxt_wr_wait = 16'(WR_DATA_WAIT_CYC);
      nxt_wr_pend = 1'b1;
    end else if (wr_pend_ff && (wr_data_start || wr_timeout)) begin
      nxt_wr_pend = 1'b0;
    end else if (wr_pend_ff) begin
      nxt_wr_wait = wr_wait_ff - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_wait_ff <= 16'h0000;
      wr_pend_ff <= 1'b0;
    end else begin
      wr_wait_ff <= nxt_wr_wait;
      wr_pend_ff <= nxt_wr_pend;
    end
  end

  logic [7:0] wr_set;
  always_comb begin
    wr_set = 8'h00; // [R18]
    wr_set[exc_status_pkg::B4_STROBE]  = wr_strobe_fault; // [R11]
    wr_set[exc_status_pkg::B4_OFFSET]  = wr_offset_fault; // [R12]
    wr_set[exc_status_pkg::B4_NO_DATA] = wr_timeout;      // [R13]
    wr_set[exc_status_pkg::B4_WPROT]   = wr_prot_fault;   // [R14]
  end
  assign wr_fb.set = wr_set;
  // Each write command restarts the write fault picture.
  assign wr_fb.clr = {8{wr_cmd || fault_clr}};

  // ==========================================================================
  // Byte 5: diagnostics
  // The disable bit mirrors its level one cycle late: its clear is the
  // inverse of the level. A diagnostic start clears the old result, but a
  // result reported in the same cycle still wins.
  logic [7:0] dg_set;
  logic [7:0] dg_clr;
  always_comb begin
    dg_set = 8'h00; // [R18]
    dg_clr = 8'h00;
    dg_set[exc_status_pkg::B5_DIAG_OFF] = diag_disable;    // [R15]
    dg_clr[exc_status_pkg::B5_DIAG_OFF] = !diag_disable;
    dg_set[exc_status_pkg::B5_DIAG_INC] = diag_incomplete; // [R16]
    dg_clr[exc_status_pkg::B5_DIAG_INC] = diag_start;
    dg_set[exc_status_pkg::B5_DIAG_ERR] = diag_error;      // [R17]
    dg_clr[exc_status_pkg::B5_DIAG_ERR] = diag_start;
  end
  assign dg_fb.set = dg_set;
  assign dg_fb.clr = dg_clr;

  // ==========================================================================
  // Status block assembly
  // Bits 7 and 5 of byte 0 are owned here; the rest come from outside.
  wire       bc_any = |bc_fb.q; // [R20]
  wire [7:0] byte0  = {1'b0,                 // [R21]
                       summary_byte_in[exc_status_pkg::B0_UNSOL],
                       bc_any,               // [R20]
                       summary_byte_in[4:0]};

  logic [7:0] blk [exc_status_pkg::BLOCK_BYTES];
  always_comb begin
    blk[0] = byte0;
    blk[1] = unsol_byte_in;
    blk[2] = bc_fb.q;
    blk[3] = hw_fb.q;
    blk[4] = wr_fb.q;
    blk[5] = dg_fb.q;
    blk[6] = head_err_byte_in;
    blk[7] = data_exc_byte_in;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bc_exception_ff <= 1'b0;
    end else begin
      bc_exception_ff <= bc_any; // [R20]
    end
  end

  // ==========================================================================
  // Status response stream
  // The block is frozen when the read is taken so the eight bytes are one
  // consistent picture even while faults keep arriving.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } stream_e;

  stream_e    state_ff;
  stream_e    nxt_state;
  logic [7:0] snap_ff [exc_status_pkg::BLOCK_BYTES];
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  // A read-status that arrives while a block is still streaming is dropped;
  // the sequencer must wait for the last byte before asking again.
  wire take_read = is_rd_status && (state_ff == ST_IDLE); // [R19]
  wire last_byte = (cnt_ff == 3'(exc_status_pkg::BLOCK_BYTES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 3'h0;
        if (take_read) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (last_byte) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < exc_status_pkg::BLOCK_BYTES; i++) begin
        snap_ff[i] <= 8'h00;
      end
    end else if (take_read) begin
      for (int i = 0; i < exc_status_pkg::BLOCK_BYTES; i++) begin
        snap_ff[i] <= blk[i]; // [R19]
      end
    end
  end

  wire sending = (state_ff == ST_SEND);

  // Busy follows the next state, so it rises the cycle after the read is
  // taken and falls on the edge that puts out the last byte.
  wire       nxt_stat_valid = sending;
  wire [7:0] nxt_stat_byte  = sending ? snap_ff[cnt_ff] : 8'h00;
  wire [2:0] nxt_stat_index = sending ? cnt_ff : 3'h0;
  wire       nxt_stat_last  = sending && last_byte;
  wire       nxt_stat_busy  = (nxt_state == ST_SEND);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_valid_ff <= 1'b0;
      stat_byte_ff  <= 8'h00;
      stat_index_ff <= 3'h0;
      stat_last_ff  <= 1'b0;
      stat_busy_ff  <= 1'b0;
    end else begin
      stat_valid_ff <= nxt_stat_valid;
      stat_byte_ff  <= nxt_stat_byte;
      stat_index_ff <= nxt_stat_index;
      stat_last_ff  <= nxt_stat_last;
      stat_busy_ff  <= nxt_stat_busy;
    end
  end

endmodule

// ===== tb/drive_exception_status_bytes_assertions.sv
// Checker for the status response stream, bound to the top ports of the block.
// Assumes the read-status code and stream timing of the package and note.
`timescale 1ns/100ps
module drive_exception_status_bytes_assertions #(
  parameter int unsigned WR_DATA_WAIT_CYC = exc_status_pkg::WR_DATA_WAIT_CYC,
  parameter int unsigned NUM_HEADS        = exc_status_pkg::NUM_HEADS
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Commands and rejections
  input wire logic       cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic       rej_late,
  input wire logic       rej_conflict,
  input wire logic       rej_unsupported,
  input wire logic       rej_bad_param,
  input wire logic       rej_bad_code,
  // Status stream
  input wire logic       stat_valid_ff,
  input wire logic [7:0] stat_byte_ff,
  input wire logic [2:0] stat_index_ff,
  input wire logic       stat_last_ff,
  input wire logic       stat_busy_ff,
  input wire logic       bc_exception_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  wire       rd_taken = cmd_strobe && cmd_code == exc_status_pkg::RD_STATUS_CODE;
  wire       any_rej  = rej_late || rej_conflict || rej_unsupported || rej_bad_param
                        || rej_bad_code;
  wire [7:0] resv_mask = (stat_index_ff == 3'h2) ? 8'h07 :
                         (stat_index_ff == 3'h3) ? 8'h19 :
                         (stat_index_ff == 3'h4) ? 8'h47 :
                         (stat_index_ff == 3'h5) ? 8'h1f : 8'h00;

  sequence body_s;
    (stat_valid_ff && !stat_last_ff)[*7] ##1
      (stat_valid_ff && stat_last_ff && stat_index_ff == 3'h7);
  endsequence

  read_stream_a: assert property (rd_taken && !stat_busy_ff |=> stat_busy_ff ##1
    (stat_index_ff == 3'h0) ##0 body_s) else $error("read stream malformed");
  idle_quiet_a: assert property (!stat_valid_ff |-> stat_byte_ff == 8'h00 &&
    stat_index_ff == 3'h0 && !stat_last_ff) else $error("stream not quiet");
  resp_type_a: assert property (stat_valid_ff && stat_index_ff == 3'h0 |->
    !stat_byte_ff[7]) else $error("byte0 bit7 set");
  summary_bit_a: assert property (stat_valid_ff && stat_index_ff == 3'h2 |->
    (|stat_byte_ff[7:3]) == $past(stat_byte_ff[5], 2)) else $error("summary flag wrong");
  unused_zero_a: assert property (stat_valid_ff |->
    (stat_byte_ff & resv_mask) == 8'h00) else $error("unused bit set");
  reject_flag_a: assert property (any_rej |-> ##2 bc_exception_ff)
    else $error("rejection not flagged");
  reject_clear_a: assert property (cmd_strobe && !rd_taken && !any_rej |-> ##2
    !bc_exception_ff) else $error("rejection flag not cleared");
  busy_span_a: assert property ($rose(stat_busy_ff) |-> stat_busy_ff[*8] ##1
    !stat_busy_ff) else $error("busy length wrong");
  last_byte_a: assert property (stat_last_ff |-> stat_valid_ff &&
    stat_index_ff == 3'h7 && !stat_busy_ff) else $error("last byte misplaced");
endmodule

bind drive_exception_status_bytes drive_exception_status_bytes_assertions #(
  .WR_DATA_WAIT_CYC(WR_DATA_WAIT_CYC), .NUM_HEADS(NUM_HEADS)) i_chk (.sys_clk, .rst,
  .cmd_strobe, .cmd_code, .rej_late, .rej_conflict, .rej_unsupported, .rej_bad_param,
  .rej_bad_code, .stat_valid_ff, .stat_byte_ff, .stat_index_ff, .stat_last_ff,
  .stat_busy_ff, .bc_exception_ff);

// ===== tb/status_reader_model.sv
// Sequencer model: issues one bus control command per go pulse, with the
// decoder's rejection causes, and gathers the 8-byte status block.
`timescale 1ns/100ps
module status_reader_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Requests from the bench
  input  wire logic        go,
  input  wire logic [7:0]  code,
  input  wire logic [4:0]  rej,
  // Command side of the drive
  output logic             cmd_strobe,
  output logic [7:0]       cmd_code,
  output logic [4:0]       rej_out,
  // Status stream
  input  wire logic        stat_valid_ff,
  input  wire logic [7:0]  stat_byte_ff,
  input  wire logic [2:0]  stat_index_ff,
  input  wire logic        stat_last_ff,
  output logic [63:0]      blk,
  output logic             done
);
  // The code lines show a changing pattern between commands, so a stale code is never read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      cmd_code   <= 8'h00;
      rej_out    <= 5'h00;
      blk        <= 64'h0;
      done       <= 1'b0;
    end else begin
      cmd_strobe <= go;
      cmd_code   <= go ? code : ~cmd_code;
      rej_out    <= go ? rej : 5'h00;
      done       <= stat_valid_ff && stat_last_ff;
      if (go) begin
        blk <= ~blk;
      end else if (stat_valid_ff) begin
        blk[{stat_index_ff, 3'b000} +: 8] <= stat_byte_ff;
      end
    end
  end
endmodule

// ===== tb/drive_exception_status_bytes_bench.sv
// Bench for the exception status bytes: drives events and levels, reads blocks.
// Assumes the sequencer model in status_reader_model and a 20-cycle write wait.
`timescale 1ns/100ps
module drive_exception_status_bytes_bench;
  logic        sys_clk, rst, go, cmd_strobe, done;
  logic [7:0]  code, cmd_code;
  logic [4:0]  rej, rej_w, haddr;
  logic [8:0]  ev;
  logic [5:0]  lv;
  logic [63:0] blk;
  logic        sv, sl, sb, bce;
  logic [7:0]  sbyte;
  logic [2:0]  sidx;
  int          num_errors, samples_checked, i;
  logic [7:0]  wtab [3] = '{8'h08, 8'h10, 8'h80};

  drive_exception_status_bytes #(.WR_DATA_WAIT_CYC(20)) i_drive_exception_status_bytes (
    .sys_clk, .rst, .cmd_strobe, .cmd_code, .rej_late(rej_w[0]), .rej_conflict(rej_w[1]),
    .rej_unsupported(rej_w[2]), .rej_bad_param(rej_w[3]), .rej_bad_code(rej_w[4]),
    .overtemp_pin(lv[0]), .volt_fault_pin(lv[1]), .head_sel_strobe(ev[0]),
    .head_sel_addr(haddr), .off_cyl_event(ev[1]), .speed_event(ev[2]), .fault_clr(ev[3]),
    .wr_cmd(ev[4]), .strobe_shift_on(lv[2]), .head_offset_on(lv[3]),
    .write_protect_on(lv[4]), .wr_data_start(ev[5]), .diag_disable(lv[5]),
    .diag_start(ev[6]), .diag_incomplete(ev[7]), .diag_error(ev[8]),
    .summary_byte_in(8'hff), .unsol_byte_in(8'ha5), .head_err_byte_in(8'h3c),
    .data_exc_byte_in(8'hc3), .stat_valid_ff(sv), .stat_byte_ff(sbyte),
    .stat_index_ff(sidx), .stat_last_ff(sl), .stat_busy_ff(sb), .bc_exception_ff(bce));

  status_reader_model i_status_reader_model (.sys_clk, .rst, .go, .code, .rej,
    .cmd_strobe, .cmd_code, .rej_out(rej_w), .stat_valid_ff(sv), .stat_byte_ff(sbyte),
    .stat_index_ff(sidx), .stat_last_ff(sl), .blk, .done);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk) ev[k] <= 1'b1;
    @(posedge sys_clk) ev[k] <= 1'b0;
    wait_n(2);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [4:0] r);
    @(posedge sys_clk) begin
      go <= 1'b1;
      code <= c;
      rej <= r;
    end
    @(posedge sys_clk) go <= 1'b0;
    wait_n(3);
  endtask

  // Byte 0 is predicted from the fixed summary input and the byte 2 expectation.
  task automatic rd(input logic [7:0] e2, e3, e4, e5);
    logic [63:0] exp;
    int n;
    exp = {8'hc3, 8'h3c, e5, e4, e3, e2, 8'ha5, 1'b0, 1'b1, |e2, 5'h1f};
    @(posedge sys_clk) begin
      go <= 1'b1;
      code <= 8'h44;
      rej <= 5'h00;
    end
    @(posedge sys_clk) go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    samples_checked += 2;
    if (blk !== exp) begin
      num_errors++;
      $display("BAD %0t block %h expected %h", $time, blk, exp);
    end
    if (bce !== (|e2) || sb !== 1'b0) begin
      num_errors++;
      $display("BAD %0t summary flag %b busy %b", $time, bce, sb);
    end
  endtask

  initial begin
    rst = 1'b1; go = 1'b0; code = 8'h00; rej = 5'h00; ev = '0; lv = '0; haddr = 5'h00;
    num_errors = 0; samples_checked = 0;
    wait_n(10);
    rst <= 1'b0;
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    for (i = 0; i < 5; i++) begin
      cmd(8'h10, 5'h01 << i);
      rd(8'h08 << i, 8'h00, 8'h00, 8'h00);
    end
    rd(8'h80, 8'h00, 8'h00, 8'h00);
    cmd(8'h10, 5'h00);
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    $display("command rejection test done");
    @(posedge sys_clk) haddr <= 5'h08;
    pulse(0);
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge sys_clk) haddr <= 5'h09;
    pulse(0);
    pulse(1);
    rd(8'h00, 8'h60, 8'h00, 8'h00);
    pulse(2);
    @(posedge sys_clk) lv[1:0] <= 2'b11;
    wait_n(5);
    rd(8'h00, 8'he6, 8'h00, 8'h00);
    @(posedge sys_clk) lv[1:0] <= 2'b00;
    wait_n(5);
    pulse(3);
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    $display("drive fault test done");
    for (i = 0; i < 3; i++) begin
      @(posedge sys_clk) lv[i + 2] <= 1'b1;
      pulse(4);
      @(posedge sys_clk) lv[i + 2] <= 1'b0;
      rd(8'h00, 8'h00, wtab[i], 8'h00);
    end
    wait_n(30);
    rd(8'h00, 8'h00, 8'h80, 8'h00);
    pulse(4);
    wait_n(25);
    rd(8'h00, 8'h00, 8'h20, 8'h00);
    pulse(4);
    pulse(5);
    wait_n(25);
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    $display("write fault test done");
    @(posedge sys_clk) lv[5] <= 1'b1;
    wait_n(3);
    rd(8'h00, 8'h00, 8'h00, 8'h20);
    pulse(7);
    rd(8'h00, 8'h00, 8'h00, 8'h60);
    pulse(8);
    rd(8'h00, 8'h00, 8'h00, 8'he0);
    pulse(6);
    @(posedge sys_clk) lv[5] <= 1'b0;
    wait_n(3);
    rd(8'h00, 8'h00, 8'h00, 8'h00);
    $display("diagnostic test done");
    close_out();
  end

  initial begin
    wait_n(3000);
    num_errors++;
    $display("BAD %0t run did not finish", $time);
    close_out();
  end
endmodule
